// *** design/pocs_pkg.sv ***
// Package of constants for the power-on configuration sequencer
package pocs_pkg;
    // Clock period in picoseconds (200 MHz)
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    // Bank-good settle time before user mode, in nanoseconds
    localparam int unsigned BANK_SETTLE_NS = 2000;
    // Settle time in clock cycles, rounded up
    localparam int unsigned BANK_SETTLE_CYC =
        (BANK_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Longest configuration time in nanoseconds
    localparam int unsigned CONFIG_TIME_NS = 450000;
    // Longest configuration time in cycles, rounded down
    localparam int unsigned CONFIG_TIME_CYC =
        (CONFIG_TIME_NS * 1000) / CLK_PERIOD_PS;
    // Default download length in cycles, within the configuration time
    localparam int unsigned DOWNLOAD_CYC_DEF = 40000;
    // Cycles for which all registers are held cleared after download
    localparam int unsigned CLEAR_CYC      = 16;
    // Width of the free-running time counter
    localparam int unsigned CNT_W          = 20;
    // Reset value of the time counter
    localparam logic [19:0] CNT_RST        = 20'h00000;

    // Sequencer states, Gray coded along off-download-wait-clear-user
    typedef enum logic [2:0]
    {
        POCS_OFF      = 3'b000,
        POCS_DOWNLOAD = 3'b001,
        POCS_BANKWAIT = 3'b011,
        POCS_CLEAR    = 3'b010,
        POCS_USER     = 3'b110,
        POCS_BROWNOUT = 3'b111
    } pocs_state_t;
endpackage

// *** design/pocs_sync.sv ***
// Two-flop synchroniser for supply indications
`timescale 1ns/1ps
module pocs_sync
#(
    parameter int unsigned WIDTH = 1
)
(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_ff;   // First stage, read only by second

    // Both stages reset low so supplies count as bad at reset
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_ff  <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// *** design/pocs_top.sv ***
// Power-on configuration sequencer with brown-out restart
// Operation
// - Start download when core crosses start threshold
// - Download plus user entry within configuration time
// - Pins tri-stated, pulled up through download
// - User mode hands pins to user logic
// - Supplies together: user mode within configuration time
// - Gate user on banks; 2 us after last unless good at download end
// - Standard: core sag resets config, tri-states pins
// - Standard: restart download when core recovers
// - Low-power: no supply monitoring in user mode
// - Low-power: restart download only after reset
// - Clear registers, release in the same cycle as pin release
// - Optional clear pin holds register clear
// - Optional output-enable pin holds pin tri-state
// - Any supply low forces output buffers off, except in low-power user mode
`timescale 1ns/1ps
module pocs_top
#(
    parameter int unsigned NUM_BANKS    = 4,
    parameter bit          LOW_POWER    = 1'b0,
    parameter int unsigned DOWNLOAD_CYC = pocs_pkg::DOWNLOAD_CYC_DEF
)
(
    input  wire logic                 SYS_CLK_IN,
    input  wire logic                 RST_N_IN,
    input  wire logic                 CORE_START_IN,
    input  wire logic                 CORE_SAG_IN,
    input  wire logic [NUM_BANKS-1:0] BANK_GOOD_IN,
    input  wire logic                 CLR_PIN_EN_IN,
    input  wire logic                 GLOBAL_REGISTER_CLEAR_N_IN,
    input  wire logic                 OE_PIN_EN_IN,
    input  wire logic                 GLOBAL_OUTPUT_ENABLE_IN,
    output logic                      DOWNLOAD_ACTIVE_OUT,
    output logic                      CONFIG_RESET_OUT,
    output logic                      REG_CLEAR_OUT,
    output logic                      PIN_TRISTATE_OUT,
    output logic                      PIN_PULLUP_OUT,
    output logic                      SUPPLY_LOW_OUTPUT_CUTOFF_OUT,
    output logic                      USER_MODE_OUT
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Download must leave room for settle and clear in the budget
    if (NUM_BANKS < 1 || DOWNLOAD_CYC < 1 ||
        DOWNLOAD_CYC + pocs_pkg::CLEAR_CYC + pocs_pkg::BANK_SETTLE_CYC
        > pocs_pkg::CONFIG_TIME_CYC ||
        DOWNLOAD_CYC >= (1 << pocs_pkg::CNT_W))
    begin : g_bad_param
        $error("pocs_top: parameters out of range");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int unsigned SW = NUM_BANKS + 2; // Synchronised width
    localparam logic [19:0] DL_END  = 20'(DOWNLOAD_CYC - 1);
    localparam logic [19:0] BS_END  = 20'(pocs_pkg::BANK_SETTLE_CYC - 1);
    localparam logic [19:0] CLR_END = 20'(pocs_pkg::CLEAR_CYC - 1);

    logic [SW-1:0]         sync_vec;      // Synchronised supply flags
    logic                  core_start;    // Core above start threshold
    logic                  core_sag;      // Core at or below sag level
    logic                  banks_good;    // Every bank powered
    pocs_pkg::pocs_state_t state_ff;      // Current state
    pocs_pkg::pocs_state_t nxt_state;     // Next state
    logic [19:0]           cnt_ff;        // Free-running time counter
    logic                  cnt_clr;       // Restart the counter
    logic                  banks_seen_ff; // Banks already good stable
    logic                  sag_event;     // Brown-out in user mode
    // All checks below use the system clock and pause in reset
    default clocking cb_sys @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    pocs_sync #(.WIDTH(SW)) u_sync
    (
        .clk_in   (SYS_CLK_IN),
        .rst_n_in (RST_N_IN),
        .async_in ({BANK_GOOD_IN, CORE_SAG_IN, CORE_START_IN}),
        .sync_out (sync_vec)
    );

    assign core_start = sync_vec[0];
    assign core_sag   = sync_vec[1];
    assign banks_good = &sync_vec[SW-1:2];

    // Monitoring stops in user mode for the low-power variant
    assign sag_event = !LOW_POWER && core_sag;

    // ------------------------------------------------------------
    // Time counter
    // ------------------------------------------------------------
    // Free-running, restarted on entry to download, wait, clear and user, and on bank drop
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            cnt_ff <= pocs_pkg::CNT_RST;
        else if (cnt_clr)
            cnt_ff <= pocs_pkg::CNT_RST;
        else
            cnt_ff <= cnt_ff + 20'h00001;
    end

    // ------------------------------------------------------------
    // Bank tracking
    // ------------------------------------------------------------
    // Banks good at the end of the download skip the 2 us settle
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            banks_seen_ff <= 1'b0;
        else if (state_ff == pocs_pkg::POCS_DOWNLOAD)
            banks_seen_ff <= banks_good;
        else if (state_ff != pocs_pkg::POCS_BANKWAIT)
            banks_seen_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        cnt_clr   = 1'b0;
        case (state_ff)
            pocs_pkg::POCS_OFF:
            begin
                // Wait for core start threshold
                if (core_start)
                begin
                    nxt_state = pocs_pkg::POCS_DOWNLOAD;
                    cnt_clr   = 1'b1;
                end
            end
            pocs_pkg::POCS_DOWNLOAD:
            begin
                // Core dropping out aborts and restarts later
                if (!core_start)
                    nxt_state = pocs_pkg::POCS_OFF;
                else if (cnt_ff == DL_END)
                begin
                    nxt_state = pocs_pkg::POCS_BANKWAIT;
                    cnt_clr   = 1'b1;
                end
            end
            pocs_pkg::POCS_BANKWAIT:
            begin
                // A bank drop restarts the settle window
                if (!core_start)
                    nxt_state = pocs_pkg::POCS_OFF;
                else if (!banks_good)
                    cnt_clr = 1'b1;
                else if (banks_seen_ff || cnt_ff == BS_END)
                begin
                    nxt_state = pocs_pkg::POCS_CLEAR;
                    cnt_clr   = 1'b1;
                end
            end
            pocs_pkg::POCS_CLEAR:
            begin
                // Fixed clear window before user release
                if (!core_start)
                    nxt_state = pocs_pkg::POCS_OFF;
                else if (cnt_ff == CLR_END)
                begin
                    nxt_state = pocs_pkg::POCS_USER;
                    cnt_clr   = 1'b1;
                end
            end
            pocs_pkg::POCS_USER:
            begin
                // Only the standard variant watches for sag
                if (sag_event)
                    nxt_state = pocs_pkg::POCS_BROWNOUT;
            end
            pocs_pkg::POCS_BROWNOUT:
            begin
                // Wait for core to recover to start level
                if (core_start && !core_sag)
                begin
                    nxt_state = pocs_pkg::POCS_DOWNLOAD;
                    cnt_clr   = 1'b1;
                end
            end
            default:
                nxt_state = pocs_pkg::POCS_OFF;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            state_ff <= pocs_pkg::POCS_OFF;
        else
            state_ff <= nxt_state;
    end

    // ------------------------------------------------------------
    // Outputs, registered from the next state except the supply-low cutoff
    // ------------------------------------------------------------
    // Outputs follow the state being entered so they line up with it
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            DOWNLOAD_ACTIVE_OUT <= 1'b0;
            CONFIG_RESET_OUT    <= 1'b1;
            USER_MODE_OUT       <= 1'b0;
            PIN_PULLUP_OUT      <= 1'b1;
        end
        else
        begin
            DOWNLOAD_ACTIVE_OUT <= nxt_state == pocs_pkg::POCS_DOWNLOAD;
            // Config held reset when off or after brown-out
            CONFIG_RESET_OUT    <= nxt_state == pocs_pkg::POCS_OFF ||
                                   nxt_state == pocs_pkg::POCS_BROWNOUT;
            USER_MODE_OUT       <= nxt_state == pocs_pkg::POCS_USER;
            // Pull-ups on until user mode
            PIN_PULLUP_OUT      <= nxt_state != pocs_pkg::POCS_USER;
        end
    end

    // Register clear: held outside user mode, or by the clear pin
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            REG_CLEAR_OUT <= 1'b1;
        else
            REG_CLEAR_OUT <= nxt_state != pocs_pkg::POCS_USER ||
                (CLR_PIN_EN_IN && !GLOBAL_REGISTER_CLEAR_N_IN);
    end

    // Tri-state: released with clear in user mode, or held by OE pin
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            PIN_TRISTATE_OUT <= 1'b1;
        else
            PIN_TRISTATE_OUT <= nxt_state != pocs_pkg::POCS_USER ||
                (OE_PIN_EN_IN && !GLOBAL_OUTPUT_ENABLE_IN);
    end

    // Supply-low cutoff; low-power user mode stops the monitoring
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            SUPPLY_LOW_OUTPUT_CUTOFF_OUT <= 1'b1;
        else if (LOW_POWER && state_ff == pocs_pkg::POCS_USER)
            SUPPLY_LOW_OUTPUT_CUTOFF_OUT <= 1'b0;
        else
            SUPPLY_LOW_OUTPUT_CUTOFF_OUT <= !core_start || !banks_good;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_dl_start: assert property (
        state_ff == pocs_pkg::POCS_OFF && core_start
        |=> state_ff == pocs_pkg::POCS_DOWNLOAD)
        else $error("download did not start");
    a_pins_held: assert property (
        DOWNLOAD_ACTIVE_OUT |-> PIN_TRISTATE_OUT && PIN_PULLUP_OUT)
        else $error("pins released during download");
    a_user_release: assert property (
        $rose(USER_MODE_OUT) && !$past(OE_PIN_EN_IN) |-> !PIN_TRISTATE_OUT)
        else $error("pins not handed over in user mode");
    a_clear_first: assert property (
        $fell(PIN_TRISTATE_OUT) && !$past(CLR_PIN_EN_IN) |-> !REG_CLEAR_OUT)
        else $error("clear released after pins");
    a_brownout: assert property (
        !LOW_POWER && state_ff == pocs_pkg::POCS_USER && core_sag
        |=> CONFIG_RESET_OUT && PIN_TRISTATE_OUT && !USER_MODE_OUT)
        else $error("brown-out did not reset");
    a_lp_nomon: assert property (
        LOW_POWER && state_ff == pocs_pkg::POCS_USER
        |=> state_ff == pocs_pkg::POCS_USER)
        else $error("low-power variant left user mode");
    a_clr_pin: assert property (
        CLR_PIN_EN_IN && !GLOBAL_REGISTER_CLEAR_N_IN |=> REG_CLEAR_OUT)
        else $error("clear pin ignored");
    a_oe_pin: assert property (
        OE_PIN_EN_IN && !GLOBAL_OUTPUT_ENABLE_IN |=> PIN_TRISTATE_OUT)
        else $error("output-enable pin ignored");
    a_restart: assert property (
        state_ff == pocs_pkg::POCS_BROWNOUT && core_start && !core_sag
        |=> DOWNLOAD_ACTIVE_OUT)
        else $error("download did not restart");
endmodule

// *** verification/pocs_top_tb.sv ***
// Self-checking bench for the power-on configuration sequencer
`timescale 1ns/1ps
module pocs_top_tb;
    // ---------------------------------------------------------------
    // Settings and signals
    // ---------------------------------------------------------------
    localparam int DL    = 20;    // Short download keeps the run brief
    localparam int NB    = 4;     // Number of I/O banks
    localparam int ENTRY = 3 + DL + 1 + pocs_pkg::CLEAR_CYC;
    localparam int LIMIT = 6000;  // Whole run needs under 3500 cycles

    // One row: pin options and the levels they give in user mode
    typedef struct {
        logic clr_en;
        logic clr_n;
        logic oe_en;
        logic oe;
        logic exp_clr;
        logic exp_tri;
    } pocs_row_t;

    logic          clk;
    logic          rst_n;
    logic          core_start;
    logic          core_sag;
    logic [NB-1:0] bank_good;
    logic          clr_en, clr_n, oe_en, oe;
    logic          dl_act, cfg_rst, reg_clr, tri_st, pull_up, cutoff, user;
    logic          lp_user;       // Low-power variant, same stimulus
    int            fail_count;
    int            checks;
    int            cyc;
    int            n;
    pocs_row_t     rows [5];

    // ---------------------------------------------------------------
    // Clock, devices and timeout
    // ---------------------------------------------------------------
    always #2.5 clk = ~clk;

    pocs_top #(.NUM_BANKS(NB), .LOW_POWER(1'b0), .DOWNLOAD_CYC(DL))
    pocs_top_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
        .CORE_START_IN(core_start), .CORE_SAG_IN(core_sag),
        .BANK_GOOD_IN(bank_good), .CLR_PIN_EN_IN(clr_en),
        .GLOBAL_REGISTER_CLEAR_N_IN(clr_n), .OE_PIN_EN_IN(oe_en),
        .GLOBAL_OUTPUT_ENABLE_IN(oe), .DOWNLOAD_ACTIVE_OUT(dl_act),
        .CONFIG_RESET_OUT(cfg_rst), .REG_CLEAR_OUT(reg_clr),
        .PIN_TRISTATE_OUT(tri_st), .PIN_PULLUP_OUT(pull_up),
        .SUPPLY_LOW_OUTPUT_CUTOFF_OUT(cutoff), .USER_MODE_OUT(user));

    // Low-power twin: only its user flag is watched
    pocs_top #(.NUM_BANKS(NB), .LOW_POWER(1'b1), .DOWNLOAD_CYC(DL))
    pocs_top_lp_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
        .CORE_START_IN(core_start), .CORE_SAG_IN(core_sag),
        .BANK_GOOD_IN(bank_good), .CLR_PIN_EN_IN(clr_en),
        .GLOBAL_REGISTER_CLEAR_N_IN(clr_n), .OE_PIN_EN_IN(oe_en),
        .GLOBAL_OUTPUT_ENABLE_IN(oe), .DOWNLOAD_ACTIVE_OUT(),
        .CONFIG_RESET_OUT(), .REG_CLEAR_OUT(), .PIN_TRISTATE_OUT(),
        .PIN_PULLUP_OUT(), .SUPPLY_LOW_OUTPUT_CUTOFF_OUT(),
        .USER_MODE_OUT(lp_user));

    // Cuts a hang short; counts as a mismatch
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            fail_count++;
            $display("[ERR] timeout expected finish seen cycle %0d", cyc);
            tally_and_finish();
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int g);
        checks++;
        if (g < lo || g > hi)
        begin
            fail_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // Wait k edges, then step past the edge so outputs have settled
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Reset with supplies and pin options down for k cycles, then
    // look at the held levels
    task automatic do_reset(input int k);
        @(posedge clk);
        rst_n      <= 1'b0;
        core_start <= 1'b0;
        core_sag   <= 1'b0;
        bank_good  <= '0;
        clr_en     <= 1'b0;
        clr_n      <= 1'b1;
        oe_en      <= 1'b0;
        oe         <= 1'b0;
        tick(k);
        chk_bit("cfg_rst", 1'b1, cfg_rst);
        chk_bit("reg_clr", 1'b1, reg_clr);
        chk_bit("tri_st", 1'b1, tri_st);
        chk_bit("pull_up", 1'b1, pull_up);
        chk_bit("cutoff", 1'b1, cutoff);
        chk_bit("user", 1'b0, user);
        chk_bit("dl_act", 1'b0, dl_act);
        @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // Count edges until user mode, bounded
    task automatic wait_user(input int bound, output int k);
        k = 0;
        while (user !== 1'b1 && k < bound)
        begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        clk = 0; rst_n = 0; core_start = 0; core_sag = 0; bank_good = '0;
        clr_en = 0; clr_n = 1; oe_en = 0; oe = 0;
        fail_count = 0; checks = 0; cyc = 0;
        // Pin options and the held clear and tri-state they should give
        rows[0] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        rows[1] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        rows[2] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        rows[3] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        rows[4] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        foreach (rows[i])
        begin
            do_reset(12);
            @(posedge clk);
            clr_en <= rows[i].clr_en; clr_n <= rows[i].clr_n;
            oe_en  <= rows[i].oe_en;  oe    <= rows[i].oe;
            core_start <= 1'b1;
            bank_good  <= '1;
            wait_user(200, n);
            chk_rng("entry", ENTRY - 2, ENTRY + 2, n);
            tick(4);
            chk_bit("reg_clr", rows[i].exp_clr, reg_clr);
            chk_bit("tri_st", rows[i].exp_tri, tri_st);
            chk_bit("cutoff", 1'b0, cutoff);
            chk_bit("pull_up", 1'b0, pull_up);
            chk_bit("lp_user", 1'b1, lp_user);
            @(posedge clk);
            clr_n <= 1'b1; oe <= 1'b1;
            tick(4);
            chk_bit("reg_clr", 1'b0, reg_clr);
            chk_bit("tri_st", 1'b0, tri_st);
            $display("row %0d done", i);
        end

        // Download start latency, then loss of core before it ends
        do_reset(12);
        @(posedge clk);
        core_start <= 1'b1;
        bank_good  <= '1;
        tick(2);
        chk_bit("dl_act", 1'b0, dl_act);
        tick(1);
        chk_bit("dl_act", 1'b1, dl_act);
        chk_bit("tri_st", 1'b1, tri_st);
        chk_bit("pull_up", 1'b1, pull_up);
        @(posedge clk);
        core_start <= 1'b0;
        tick(4);
        chk_bit("dl_act", 1'b0, dl_act);
        chk_bit("cutoff", 1'b1, cutoff);
        $display("start and abort done");

        // Last bank powered long after the download
        do_reset(12);
        @(posedge clk);
        core_start <= 1'b1;
        bank_good  <= 4'he;
        tick(ENTRY + 40);
        chk_bit("user", 1'b0, user);
        chk_bit("tri_st", 1'b1, tri_st);
        chk_bit("cutoff", 1'b1, cutoff);
        @(posedge clk);
        bank_good <= '1;
        wait_user(1000, n);
        chk_rng("bank_settle", pocs_pkg::BANK_SETTLE_CYC,
                pocs_pkg::BANK_SETTLE_CYC + pocs_pkg::CLEAR_CYC + 6, n);
        $display("late bank done");

        // Brown-out in user mode, then recovery
        @(posedge clk);
        core_sag <= 1'b1;
        tick(3);
        chk_bit("user", 1'b0, user);
        chk_bit("cfg_rst", 1'b1, cfg_rst);
        chk_bit("tri_st", 1'b1, tri_st);
        chk_bit("lp_user", 1'b1, lp_user);
        @(posedge clk);
        core_sag <= 1'b0;
        wait_user(300, n);
        chk_rng("restart", ENTRY - 2, ENTRY + 4, n);
        chk_bit("lp_user", 1'b1, lp_user);
        $display("brown-out done");

        // Core lost in user mode: only the standard part notices, and
        // the low-power part needs a full power cycle to restart
        @(posedge clk);
        core_start <= 1'b0;
        core_sag   <= 1'b1;
        tick(4);
        chk_bit("user", 1'b0, user);
        chk_bit("lp_user", 1'b1, lp_user);
        do_reset(2000);
        @(posedge clk);
        core_start <= 1'b1;
        bank_good  <= '1;
        wait_user(300, n);
        chk_rng("lp_restart", ENTRY - 2, ENTRY + 2, n);
        chk_bit("lp_user", 1'b1, lp_user);
        $display("low-power restart done");
        tally_and_finish();
    end
endmodule
